/* File: adc_chan_pkg.sv */
// package for the converter channel control block: register indices, fields, reset values
// assumes an apb slave with 32-bit data, one register per aligned word
package adc_chan_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_POS_SELECT = 4'h1;
  localparam logic [3:0] IDX_IRQ_CONTROL = 4'h2;
  localparam logic [3:0] IDX_IRQ_FLAGS = 4'h3;
  localparam logic [3:0] IDX_RESULT_LOW = 4'h4;
  localparam logic [3:0] IDX_RESULT_HIGH = 4'h5;
  localparam logic [3:0] IDX_INPUT_SCAN = 4'h6;
  localparam logic [3:0] IDX_RESULT_FORMAT = 4'h8;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int COND_LSB = 2;
  localparam int LEVEL_LSB = 0;
  localparam int FLAG_BIT = 0;
  localparam int SPAN_LSB = 0;
  localparam int STEP_LSB = 4;
  localparam int POS_LSB = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] SCAN_RESET = 8'h00;
  localparam logic [3:0] POS_RESET = 4'h0;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] COND_DONE = 2'h0;
  localparam logic [1:0] COND_BELOW = 2'h1;
  localparam logic [1:0] COND_ABOVE = 2'h3;

  typedef enum logic [1:0] {
    FMT_RIGHT12,
    FMT_LEFT12,
    FMT_EIGHT
  } result_format_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [1:0] irq_condition_select;
    logic [1:0] irq_priority_level;
    logic irq_flag;
    logic [3:0] scan_span;
    logic [3:0] scan_step;
    logic [3:0] positive_input_select;
    logic [1:0] format;
    logic signed_mode;
    logic [15:0] channel_result_word;
    logic [1:0] irq_request;
    logic [3:0] mux_out;
    apb_rsp_t rsp;
  } state_t;

endpackage : adc_chan_pkg

/* File: adc_channel_irq_result_scan.sv */
// converter channel control: interrupt flag, result formatting, positive input scan
// assumes conv_done is a one-cycle strobe on core_clk with result and compare flags valid
// in the same cycle, and vector_taken is a one-cycle strobe from the interrupt controller
`timescale 1ns/100ps
`default_nettype none

module adc_channel_irq_result_scan (
  input wire logic core_clk,
  input wire logic reset,
  input wire adc_chan_pkg::apb_req_t apb_req,
  output var adc_chan_pkg::apb_rsp_t apb_rsp,
  input wire logic conv_done,
  input wire logic compare_below,
  input wire logic compare_above,
  input wire logic [11:0] conv_result,
  input wire logic vector_taken,
  output logic [1:0] irq_request,
  output logic [3:0] positive_input_sel
);

  adc_chan_pkg::state_t s_q;
  adc_chan_pkg::state_t s_d;
  logic [7:0] res_low;
  logic [7:0] res_high;
  logic flag_event;
  logic wr_acc;
  logic rd_acc;
  logic [3:0] idx;

  // ----------------------------------------------------------------
  // result byte view
  // ----------------------------------------------------------------
  always_comb begin
    res_low = s_q.channel_result_word[7:0];
    res_high = s_q.channel_result_word[15:8];
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    idx = apb_req.paddr[5:2];
    wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
    // read data fetched in setup so it stands beside ready in the access phase
    rd_acc = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
    // ready registered from setup: access phase has no wait state
    s_d.rsp.pready = apb_req.psel && !apb_req.penable;
    s_d.rsp.pslverr = 1'b0;
    s_d.rsp.prdata = s_q.rsp.prdata;

    case (s_q.irq_condition_select)
      adc_chan_pkg::COND_DONE: flag_event = conv_done;
      adc_chan_pkg::COND_BELOW: flag_event = conv_done && compare_below;
      adc_chan_pkg::COND_ABOVE: flag_event = conv_done && compare_above;
      default: flag_event = 1'b0;
    endcase

    if (conv_done) begin
      // result word formatted at capture; two's complement sign-extended in signed mode, except in left format
      case (adc_chan_pkg::result_format_t'(s_q.format))
        adc_chan_pkg::FMT_LEFT12:
          s_d.channel_result_word = {conv_result[11:4], conv_result[3:0], 4'h0};
        adc_chan_pkg::FMT_EIGHT:
          s_d.channel_result_word = {{8{s_q.signed_mode & conv_result[7]}},
                                     conv_result[7:0]};
        default:
          s_d.channel_result_word = {{4{s_q.signed_mode & conv_result[11]}},
                                     conv_result[11:0]};
      endcase
      if (s_q.scan_span != 4'h0) begin
        if (s_q.scan_step == s_q.scan_span) begin
          s_d.scan_step = 4'h0;
        end else begin
          s_d.scan_step = 4'(s_q.scan_step + 4'h1);
        end
      end
    end

    if (wr_acc) begin
      case (idx)
        adc_chan_pkg::IDX_IRQ_CONTROL: begin
          s_d.irq_condition_select = apb_req.pwdata[adc_chan_pkg::COND_LSB +: 2];
          s_d.irq_priority_level = apb_req.pwdata[adc_chan_pkg::LEVEL_LSB +: 2];
        end
        adc_chan_pkg::IDX_INPUT_SCAN: begin
          s_d.scan_span = apb_req.pwdata[adc_chan_pkg::SPAN_LSB +: 4];
          s_d.scan_step = apb_req.pwdata[adc_chan_pkg::STEP_LSB +: 4];
        end
        adc_chan_pkg::IDX_POS_SELECT:
          s_d.positive_input_select = apb_req.pwdata[adc_chan_pkg::POS_LSB +: 4];
        adc_chan_pkg::IDX_RESULT_FORMAT: begin
          s_d.format = apb_req.pwdata[1:0];
          s_d.signed_mode = apb_req.pwdata[4];
        end
        default: ;
      endcase
    end

    // flag: the set wins over either clear so no event is lost
    if (flag_event) begin
      s_d.irq_flag = 1'b1;
    end else if (vector_taken) begin
      s_d.irq_flag = 1'b0;
    end else if (wr_acc && idx == adc_chan_pkg::IDX_IRQ_FLAGS &&
                 apb_req.pwdata[adc_chan_pkg::FLAG_BIT]) begin
      s_d.irq_flag = 1'b0;
    end

    if (rd_acc) begin
      case (idx)
        adc_chan_pkg::IDX_POS_SELECT:
          s_d.rsp.prdata = {25'h0, s_q.positive_input_select, 3'h0};
        adc_chan_pkg::IDX_IRQ_CONTROL:
          s_d.rsp.prdata = {28'h0, s_q.irq_condition_select, s_q.irq_priority_level};
        adc_chan_pkg::IDX_IRQ_FLAGS: s_d.rsp.prdata = {31'h0, s_q.irq_flag};
        adc_chan_pkg::IDX_RESULT_LOW: s_d.rsp.prdata = {24'h0, res_low};
        adc_chan_pkg::IDX_RESULT_HIGH: s_d.rsp.prdata = {24'h0, res_high};
        adc_chan_pkg::IDX_INPUT_SCAN: s_d.rsp.prdata = {24'h0, s_q.scan_step, s_q.scan_span};
        adc_chan_pkg::IDX_RESULT_FORMAT:
          s_d.rsp.prdata = {27'h0, s_q.signed_mode, 2'h0, s_q.format};
        default: s_d.rsp.prdata = 32'h0;
      endcase
    end

    // request only when enabled and flag set, level carried to the controller
    s_d.irq_request = s_d.irq_flag ? s_d.irq_priority_level : 2'h0;
    // sum wraps modulo sixteen on purpose
    s_d.mux_out = 4'(s_d.positive_input_select +
                     ((s_d.scan_span != 4'h0) ? s_d.scan_step : 4'h0));
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = s_q.rsp;
  assign irq_request = s_q.irq_request;
  assign positive_input_sel = s_q.mux_out;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  flag_set_done_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && s_q.irq_condition_select == 2'h0 |=> s_q.irq_flag)
    else $error("flag not set on done");
  flag_below_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && !compare_below && s_q.irq_condition_select == 2'h1 && !s_q.irq_flag
    |=> !s_q.irq_flag)
    else $error("flag set without below");
  vector_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    vector_taken && !conv_done |=> !s_q.irq_flag)
    else $error("vector did not clear flag");
  w1c_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_acc && idx == 4'h3 && apb_req.pwdata[0] && !conv_done |=> !s_q.irq_flag)
    else $error("write one did not clear");
  irq_follow_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.irq_flag && s_q.irq_priority_level != 2'h0 |-> s_q.irq_request != 2'h0)
    else $error("request missing");
  irq_off_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.irq_priority_level == 2'h0 |-> s_q.irq_request == 2'h0)
    else $error("request while disabled");
  step_wrap_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && !wr_acc && s_q.scan_span != 4'h0 && s_q.scan_step == s_q.scan_span
    |=> s_q.scan_step == 4'h0)
    else $error("step did not wrap");
  mux_sum_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.scan_span != 4'h0 |-> s_q.mux_out == 4'(s_q.positive_input_select + s_q.scan_step))
    else $error("mux sum wrong");
  left_fmt_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && s_q.format == 2'h1 && !wr_acc
    |=> s_q.channel_result_word == {$past(conv_result), 4'h0})
    else $error("left format wrong");

  // ----------------------------------------------------------------
  // read data checks
  // ----------------------------------------------------------------
  flag_read_a: assert property (@(posedge core_clk) disable iff (reset)
    rd_acc && idx == adc_chan_pkg::IDX_IRQ_FLAGS
    |=> apb_rsp.prdata == {31'h0, $past(s_q.irq_flag)})
    else $error("flag read wrong");

  low_read_a: assert property (@(posedge core_clk) disable iff (reset)
    rd_acc && idx == adc_chan_pkg::IDX_RESULT_LOW
    |=> apb_rsp.prdata == {24'h0, $past(s_q.channel_result_word[7:0])})
    else $error("low byte read wrong");

  high_read_a: assert property (@(posedge core_clk) disable iff (reset)
    rd_acc && idx == adc_chan_pkg::IDX_RESULT_HIGH
    |=> apb_rsp.prdata == {24'h0, $past(s_q.channel_result_word[15:8])})
    else $error("high byte read wrong");

  scan_read_a: assert property (@(posedge core_clk) disable iff (reset)
    rd_acc && idx == adc_chan_pkg::IDX_INPUT_SCAN
    |=> apb_rsp.prdata == {24'h0, $past(s_q.scan_step), $past(s_q.scan_span)})
    else $error("scan read wrong");

  ctrl_read_a: assert property (@(posedge core_clk) disable iff (reset)
    rd_acc && idx == adc_chan_pkg::IDX_IRQ_CONTROL
    |=> apb_rsp.prdata[3:0] == {$past(s_q.irq_condition_select),
                                $past(s_q.irq_priority_level)})
    else $error("control read wrong");

  // ----------------------------------------------------------------
  // flag checks
  // ----------------------------------------------------------------
  above_set_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && compare_above && s_q.irq_condition_select == adc_chan_pkg::COND_ABOVE
    |=> s_q.irq_flag)
    else $error("flag not set above");

  below_set_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && compare_below && s_q.irq_condition_select == adc_chan_pkg::COND_BELOW
    |=> s_q.irq_flag)
    else $error("flag not set below");

  above_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && !compare_above && s_q.irq_condition_select == adc_chan_pkg::COND_ABOVE &&
    !s_q.irq_flag |=> !s_q.irq_flag)
    else $error("flag set without above");

  reserved_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.irq_condition_select == 2'h2 && !s_q.irq_flag
    |=> !s_q.irq_flag)
    else $error("reserved condition set flag");

  no_event_a: assert property (@(posedge core_clk) disable iff (reset)
    !conv_done && !s_q.irq_flag
    |=> !s_q.irq_flag)
    else $error("flag set without conversion");

  flag_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.irq_flag && !vector_taken &&
    !(wr_acc && idx == adc_chan_pkg::IDX_IRQ_FLAGS && apb_req.pwdata[0]) |=> s_q.irq_flag)
    else $error("flag lost");

  zero_keep_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_acc && idx == adc_chan_pkg::IDX_IRQ_FLAGS && !apb_req.pwdata[0] &&
    s_q.irq_flag && !vector_taken |=> s_q.irq_flag)
    else $error("zero write cleared flag");

  set_wins_a: assert property (@(posedge core_clk) disable iff (reset)
    flag_event && vector_taken
    |=> s_q.irq_flag)
    else $error("clear beat set");

  // ----------------------------------------------------------------
  // request checks
  // ----------------------------------------------------------------
  irq_level_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.irq_flag
    |-> s_q.irq_request == s_q.irq_priority_level)
    else $error("request level wrong");

  irq_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    !s_q.irq_flag
    |-> s_q.irq_request == 2'h0)
    else $error("request without flag");

  // ----------------------------------------------------------------
  // format checks
  // ----------------------------------------------------------------
  right_fmt_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && s_q.format == 2'h0
    |=> s_q.channel_result_word ==
        {{4{$past(s_q.signed_mode) & $past(conv_result[11])}}, $past(conv_result)})
    else $error("right format wrong");

  eight_fmt_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && s_q.format == 2'h2
    |=> s_q.channel_result_word ==
        {{8{$past(s_q.signed_mode) & $past(conv_result[7])}}, $past(conv_result[7:0])})
    else $error("eight-bit format wrong");

  left_low_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && s_q.format == 2'h1
    |=> s_q.channel_result_word[3:0] == 4'h0)
    else $error("left low bits not zero");

  word_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    !conv_done
    |=> $stable(s_q.channel_result_word))
    else $error("result changed without conversion");

  fmt_write_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_acc && idx == adc_chan_pkg::IDX_RESULT_FORMAT
    |=> s_q.signed_mode == $past(apb_req.pwdata[4]))
    else $error("signed mode not stored");

  // ----------------------------------------------------------------
  // scan checks
  // ----------------------------------------------------------------
  step_inc_a: assert property (@(posedge core_clk) disable iff (reset)
    conv_done && !wr_acc && s_q.scan_span != 4'h0 && s_q.scan_step != s_q.scan_span
    |=> s_q.scan_step == 4'($past(s_q.scan_step) + 4'h1))
    else $error("step did not advance");

  step_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.scan_span == 4'h0 && !wr_acc
    |=> $stable(s_q.scan_step))
    else $error("step moved while scan off");

  step_strobe_a: assert property (@(posedge core_clk) disable iff (reset)
    !conv_done && !wr_acc
    |=> $stable(s_q.scan_step))
    else $error("step moved without conversion");

  mux_base_a: assert property (@(posedge core_clk) disable iff (reset)
    s_q.scan_span == 4'h0
    |-> s_q.mux_out == s_q.positive_input_select)
    else $error("base select wrong");

  // ----------------------------------------------------------------
  // register write checks
  // ----------------------------------------------------------------
  level_write_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_acc && idx == adc_chan_pkg::IDX_IRQ_CONTROL
    |=> s_q.irq_priority_level == $past(apb_req.pwdata[1:0]))
    else $error("level not stored");

  cond_write_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_acc && idx == adc_chan_pkg::IDX_IRQ_CONTROL
    |=> s_q.irq_condition_select == $past(apb_req.pwdata[3:2]))
    else $error("condition not stored");

  pos_write_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_acc && idx == adc_chan_pkg::IDX_POS_SELECT
    |=> s_q.positive_input_select == $past(apb_req.pwdata[6:3]))
    else $error("base select not stored");

  span_write_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_acc && idx == adc_chan_pkg::IDX_INPUT_SCAN
    |=> s_q.scan_span == $past(apb_req.pwdata[3:0]))
    else $error("span not stored");

  step_write_a: assert property (@(posedge core_clk) disable iff (reset)
    wr_acc && idx == adc_chan_pkg::IDX_INPUT_SCAN
    |=> s_q.scan_step == $past(apb_req.pwdata[7:4]))
    else $error("step not stored");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------
  done_cov_c: cover property (@(posedge core_clk) conv_done && s_q.irq_condition_select == 2'h0);
  left_cov_c: cover property (@(posedge core_clk) conv_done && s_q.format == 2'h1);
  w1c_cov_c: cover property (@(posedge core_clk) wr_acc && idx == adc_chan_pkg::IDX_IRQ_FLAGS &&
    apb_req.pwdata[0] && s_q.irq_flag);
  wrap_cov_c: cover property (@(posedge core_clk) conv_done && s_q.scan_span != 4'h0 &&
    s_q.scan_step == s_q.scan_span);
  clear_cov_c: cover property (@(posedge core_clk) vector_taken && s_q.irq_flag);

endmodule : adc_channel_irq_result_scan
`default_nettype wire

/* File: adc_channel_irq_result_scan_bench.sv */
// self-checking bench for the converter channel control block
// assumes the design package is compiled first; drives apb and strobes itself
`timescale 1ns/100ps
`default_nettype none
module adc_channel_irq_result_scan_bench;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  adc_chan_pkg::apb_req_t req = '0;
  adc_chan_pkg::apb_rsp_t apb_rsp;
  logic conv_done = 1'b0;
  logic below = 1'b0;
  logic above = 1'b0;
  logic [11:0] res = 12'h000;
  logic vector_taken = 1'b0;
  logic [1:0] irq_request;
  logic [3:0] positive_input_sel;
  logic [31:0] d;
  int fail_count = 0;
  int num_checks = 0;
  always #2.5 core_clk = ~core_clk;
  adc_channel_irq_result_scan dut (.core_clk(core_clk), .reset(reset), .apb_req(req),
    .apb_rsp(apb_rsp), .conv_done(conv_done), .compare_below(below), .compare_above(above),
    .conv_result(res), .vector_taken(vector_taken), .irq_request(irq_request),
    .positive_input_sel(positive_input_sel));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // idle edge first, so release and next setup never share a time step
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= {6'h00, idx, 2'h0};
    req.pwdata <= wd;
    @(posedge core_clk);
    req.penable <= 1'b1;
    // look mid-cycle where ready and data are settled; both stand through the next edge
    do begin
      @(negedge core_clk);
      n++;
      rd = apb_rsp.prdata;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    @(posedge core_clk);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  // read data stands beside ready, so one access suffices
  task automatic rd(input logic [3:0] idx, output logic [31:0] v);
    apb(1'b0, idx, 32'h0, v);
  endtask : rd
  task automatic wr(input logic [3:0] idx, input logic [31:0] v);
    apb(1'b1, idx, v, d);
  endtask : wr
  task automatic conv(input logic [11:0] r, input logic b, input logic a);
    @(posedge core_clk);
    conv_done <= 1'b1;
    res <= r;
    below <= b;
    above <= a;
    @(posedge core_clk);
    conv_done <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : conv
  task automatic flag_is(input logic f, input logic [1:0] lvl);
    rd(adc_chan_pkg::IDX_IRQ_FLAGS, d);
    chk(d, {31'h0, f});
    chk({30'h0, irq_request}, {30'h0, f ? lvl : 2'h0});
  endtask : flag_is
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd(adc_chan_pkg::IDX_IRQ_CONTROL, d);
    chk(d, 32'h0);
    rd(adc_chan_pkg::IDX_INPUT_SCAN, d);
    chk(d, 32'h0);
    rd(adc_chan_pkg::IDX_RESULT_HIGH, d);
    chk(d, 32'h0);
    rd(4'hf, d);
    chk(d, 32'h0);
  endtask : t_reset
  task automatic t_irq;
    wr(adc_chan_pkg::IDX_IRQ_CONTROL, 32'h02);
    conv(12'h123, 1'b0, 1'b0);
    flag_is(1'b1, 2'h2);
    wr(adc_chan_pkg::IDX_IRQ_FLAGS, 32'h0);
    flag_is(1'b1, 2'h2);
    wr(adc_chan_pkg::IDX_IRQ_FLAGS, 32'h1);
    flag_is(1'b0, 2'h2);
    wr(adc_chan_pkg::IDX_IRQ_CONTROL, 32'h05);
    conv(12'h001, 1'b0, 1'b1);
    flag_is(1'b0, 2'h1);
    conv(12'h001, 1'b1, 1'b0);
    flag_is(1'b1, 2'h1);
    @(posedge core_clk);
    vector_taken <= 1'b1;
    @(posedge core_clk);
    vector_taken <= 1'b0;
    flag_is(1'b0, 2'h1);
    wr(adc_chan_pkg::IDX_IRQ_CONTROL, 32'h0f);
    conv(12'h001, 1'b1, 1'b0);
    flag_is(1'b0, 2'h3);
    conv(12'h001, 1'b0, 1'b1);
    flag_is(1'b1, 2'h3);
    wr(adc_chan_pkg::IDX_IRQ_FLAGS, 32'h1);
    wr(adc_chan_pkg::IDX_IRQ_CONTROL, 32'h0b);
    conv(12'h001, 1'b1, 1'b1);
    flag_is(1'b0, 2'h3);
  endtask : t_irq
  task automatic fmt(input logic [31:0] f, input logic [11:0] r, input logic [7:0] lo,
                     input logic [7:0] hi);
    wr(adc_chan_pkg::IDX_RESULT_FORMAT, f);
    conv(r, 1'b0, 1'b0);
    rd(adc_chan_pkg::IDX_RESULT_LOW, d);
    chk(d, {24'h0, lo});
    rd(adc_chan_pkg::IDX_RESULT_HIGH, d);
    chk(d, {24'h0, hi});
  endtask : fmt
  task automatic t_format;
    fmt(32'h00, 12'ha5c, 8'h5c, 8'h0a);
    fmt(32'h10, 12'ha5c, 8'h5c, 8'hfa);
    fmt(32'h01, 12'ha5c, 8'hc0, 8'ha5);
    fmt(32'h02, 12'h0a5, 8'ha5, 8'h00);
    fmt(32'h12, 12'h0a5, 8'ha5, 8'hff);
  endtask : t_format
  task automatic t_scan;
    logic [3:0] e [4];
    e = '{4'he, 4'hf, 4'h0, 4'he};
    wr(adc_chan_pkg::IDX_POS_SELECT, 32'h70);
    wr(adc_chan_pkg::IDX_INPUT_SCAN, 32'h02);
    for (int i = 0; i < 4; i++) begin
      @(negedge core_clk);
      chk({28'h0, positive_input_sel}, {28'h0, e[i]});
      conv(12'h000, 1'b0, 1'b0);
    end
    wr(adc_chan_pkg::IDX_INPUT_SCAN, 32'h00);
    conv(12'h000, 1'b0, 1'b0);
    chk({28'h0, positive_input_sel}, 32'he);
  endtask : t_scan
  task automatic finish_test;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_irq();
    t_format();
    t_scan();
    finish_test();
  end
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule : adc_channel_irq_result_scan_bench
`default_nettype wire
